// *** src/npc_conn.sv ***
// per-port connection state machine with nexus loss detection
`timescale 1ns/100ps
`include "npc_defines.svh"
module npc_conn #(
    parameter int unsigned DW    = 8,
    parameter int unsigned TO_W  = 32,
    parameter logic [TO_W-1:0] ACK_TO_CYC = TO_W'(`NPC_ACK_TO_CYC)
)
(
    // clock and reset
    input  wire logic            sys_clk_i,
    input  wire logic            reset_i,
    // service requests from local port
    input  wire logic [2:0]      req_i,
    input  wire logic [DW-1:0]   req_data_i,
    // network side results
    input  wire logic            accept_ok_i,
    input  wire logic            accept_fail_i,
    input  wire logic            connect_ok_i,
    input  wire logic            connect_fail_i,
    input  wire logic            remote_req_i,
    input  wire logic            rx_valid_i,
    input  wire logic [DW-1:0]   rx_data_i,
    input  wire logic            rx_fail_i,
    input  wire logic            disc_ind_i,
    // nexus loss sources
    input  wire logic            login_tx_i,
    input  wire logic            login_rx_i,
    input  wire logic            login_reset_flag_i,
    input  wire logic            ack_of_reset_i,
    input  wire logic            host_sense_i,
    input  wire logic            remote_reset_i,
    input  wire logic            serial_disc_i,
    // time-out control
    input  wire logic            serial_mode_i,
    input  wire logic            param_chg_i,
    input  wire logic [TO_W-1:0] param_to_i,
    input  wire logic            to_iu_i,
    input  wire logic [TO_W-1:0] to_iu_val_i,
    // network operations
    output logic [2:0]           net_op_o,
    output logic                 tx_valid_o,
    output logic [DW-1:0]        tx_data_o,
    output logic                 refuse_remote_o,
    // indications to local port
    output logic [2:0]           state_o,
    output logic                 connected_o,
    output logic                 disconnected_o,
    output logic                 received_o,
    output logic [DW-1:0]        rcv_data_o,
    output logic                 reject_o,
    output logic                 nexus_loss_o,
    output logic                 host_present_o,
    output logic [TO_W-1:0]      ack_to_o
);
    typedef struct packed
    {
        npc_pkg::npc_state_t st;
        npc_pkg::npc_op_t    op;
        logic                tx_v;
        logic [DW-1:0]       tx_d;
        logic                refuse;
        logic                conn;
        logic                disc;
        logic                rcv;
        logic [DW-1:0]       rcv_d;
        logic                rej;
        logic                nexus;
        logic                sense_q;
        logic                present;
        logic                rcv_pend;
    } npc_st_t;

    npc_st_t st_r;
    npc_st_t st_nxt;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt        = st_r;
        st_nxt.op     = npc_pkg::NPC_OP_NONE;
        st_nxt.tx_v   = 1'b0;
        st_nxt.conn   = 1'b0;
        st_nxt.disc   = 1'b0;
        st_nxt.rcv    = 1'b0;
        st_nxt.rej    = 1'b0;
        st_nxt.nexus  = 1'b0;
        st_nxt.refuse = 1'b0;
        unique case (st_r.st)
            npc_pkg::NPC_NOT_CONN:
            begin
                st_nxt.refuse   = remote_req_i;
                st_nxt.rcv_pend = 1'b0;
                if (req_i == `NPC_REQ_LISTEN)
                begin
                    st_nxt.st = npc_pkg::NPC_LISTEN;
                    st_nxt.op = npc_pkg::NPC_OP_LISTEN;
                end
                else if (req_i == `NPC_REQ_CONNECT)
                begin
                    st_nxt.st = npc_pkg::NPC_CONNING;
                    st_nxt.op = npc_pkg::NPC_OP_OPEN;
                end
                else if (req_i != `NPC_REQ_NONE)
                    st_nxt.rej = 1'b1;
            end
            npc_pkg::NPC_LISTEN:
            begin
                // received characters are dropped here
                if (req_i == `NPC_REQ_CONNECT)
                begin
                    st_nxt.st = npc_pkg::NPC_CONNING;
                    st_nxt.op = npc_pkg::NPC_OP_OPEN;
                end
                else if (req_i == `NPC_REQ_DISCON || accept_fail_i)
                begin
                    st_nxt.st   = npc_pkg::NPC_NOT_CONN;
                    st_nxt.op   = npc_pkg::NPC_OP_CLOSE;
                    st_nxt.disc = 1'b1;
                end
                else if (accept_ok_i)
                begin
                    st_nxt.st   = npc_pkg::NPC_CONN;
                    st_nxt.conn = 1'b1;
                end
                else if (req_i != `NPC_REQ_NONE)
                    st_nxt.rej = 1'b1;
            end
            npc_pkg::NPC_CONNING:
            begin
                // chars and remote requests ignored meanwhile
                if (req_i == `NPC_REQ_DISCON || connect_fail_i)
                begin
                    st_nxt.st   = npc_pkg::NPC_NOT_CONN;
                    st_nxt.op   = npc_pkg::NPC_OP_CLOSE;
                    st_nxt.disc = 1'b1;
                end
                else if (connect_ok_i)
                begin
                    st_nxt.st   = npc_pkg::NPC_CONN;
                    st_nxt.conn = 1'b1;
                end
                else if (req_i != `NPC_REQ_NONE)
                    st_nxt.rej = 1'b1;
            end
            npc_pkg::NPC_CONN:
            begin
                if (disc_ind_i)
                begin
                    st_nxt.st   = npc_pkg::NPC_NOT_CONN;
                    st_nxt.op   = npc_pkg::NPC_OP_CLOSE;
                    st_nxt.disc = 1'b1;
                end
                else
                begin
                    if (req_i == `NPC_REQ_SEND)
                    begin
                        st_nxt.tx_v = 1'b1;
                        st_nxt.tx_d = req_data_i;
                    end
                    else if (req_i == `NPC_REQ_RECEIVE)
                        st_nxt.rcv_pend = 1'b1;
                    else if (req_i == `NPC_REQ_DISCON)
                    begin
                        st_nxt.st = npc_pkg::NPC_DISCING;
                        st_nxt.op = npc_pkg::NPC_OP_SHUT;
                    end
                    else if (req_i != `NPC_REQ_NONE)
                        st_nxt.rej = 1'b1;
                    if (rx_valid_i)
                    begin
                        st_nxt.rcv   = 1'b1;
                        st_nxt.rcv_d = rx_data_i;
                    end
                end
            end
            npc_pkg::NPC_DISCING:
            begin
                st_nxt.refuse = remote_req_i;
                if (rx_fail_i)
                begin
                    st_nxt.st   = npc_pkg::NPC_NOT_CONN;
                    st_nxt.op   = npc_pkg::NPC_OP_CLOSE;
                    st_nxt.disc = 1'b1;
                end
                else
                begin
                    if (req_i == `NPC_REQ_RECEIVE)
                        st_nxt.rcv_pend = 1'b1;
                    else if (req_i != `NPC_REQ_NONE)
                        st_nxt.rej = 1'b1;
                    if (rx_valid_i)
                    begin
                        st_nxt.rcv   = 1'b1;
                        st_nxt.rcv_d = rx_data_i;
                    end
                end
            end
            default:
            begin
                st_nxt.st = npc_pkg::NPC_NOT_CONN;
            end
        endcase

        // ------------------------------------------------------------
        // nexus loss; network disconnect counts too, a design option
        // ------------------------------------------------------------
        st_nxt.sense_q = host_sense_i;
        st_nxt.present = host_sense_i;
        if ((login_tx_i || login_rx_i) && login_reset_flag_i)
            st_nxt.nexus = 1'b1;
        if (ack_of_reset_i)
            st_nxt.nexus = 1'b1;
        if ((st_r.sense_q && !host_sense_i) || remote_reset_i)
            st_nxt.nexus = 1'b1;
        if (serial_disc_i || (st_nxt.disc && `NPC_NET_NEXUS_ON_DISC))
            st_nxt.nexus = 1'b1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st_r    <= '0;
            st_r.st <= npc_pkg::NPC_NOT_CONN;
        end
        else
            st_r <= st_nxt;
    end

    // ------------------------------------------------------------
    // time-out
    // ------------------------------------------------------------
    npc_timeout #(
        .W    (TO_W),
        .INIT (ACK_TO_CYC)
    ) u_to (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .serial_mode_i (serial_mode_i),
        .param_chg_i   (param_chg_i),
        .param_to_i    (param_to_i),
        .to_iu_i       (to_iu_i),
        .to_iu_val_i   (to_iu_val_i),
        .ack_to_o      (ack_to_o)
    );

    assign net_op_o        = st_r.op;
    assign tx_valid_o      = st_r.tx_v;
    assign tx_data_o       = st_r.tx_d;
    assign refuse_remote_o = st_r.refuse;
    assign state_o         = st_r.st;
    assign connected_o     = st_r.conn;
    assign disconnected_o  = st_r.disc;
    assign received_o      = st_r.rcv;
    assign rcv_data_o      = st_r.rcv_d;
    assign reject_o        = st_r.rej;
    assign nexus_loss_o    = st_r.nexus;
    assign host_present_o  = st_r.present;
endmodule : npc_conn

// *** src/npc_defines.svh ***
// constants for the network port connection manager
// What this block does
// - after hard reset every per-port machine starts in not-connected
// - not-connected takes connect/listen, rejects rest, refuses remote, drops chars
// - listening awaits remote, drops chars, accept success gives connected
// - listening failed accept returns to not-connected, raises disconnected
// - listening with connect request frees listen resources, goes connecting
// - entering connecting issues an active open toward remote port
// - connecting accepts disconnect, rejects listen/send/receive, drops chars
// - connecting to not-connected on local disconnect or remote refusal
// - connecting to connected with indication when remote accepts
// - connected sends accepted data, services receive, raises received
// - connected refuses local connect requests
// - connected disconnect request starts shutdown, goes disconnecting
// - connected with disconnected indication goes straight to not-connected
// - disconnecting takes no new send data but still passes received data
// - disconnecting rejects all but receive, refuses remote, serves receive
// - disconnecting failed receive goes not-connected, raises disconnected
// - nexus loss on sending or receiving login with login reset flag one
// - nexus loss on ack answering own device reset unit
// - nexus loss on presence sense falling or remote reset line asserted
// - nexus loss on serial port disconnected; network port optional
// - network ack time-out starts at 2.5 s, changes only on time-out unit
// - serial port recomputes ack time-out on parameter change, later frames
// - drive device uses host presence sense to tell controller attached
`ifndef NPC_DEFINES_SVH
`define NPC_DEFINES_SVH
`define NPC_CLK_HZ        50000000
`define NPC_ACK_TO_MS     2500
`define NPC_ACK_TO_CYC    ((`NPC_ACK_TO_MS) * (`NPC_CLK_HZ / 1000))
`define NPC_REQ_NONE      3'h0
`define NPC_REQ_CONNECT   3'h1
`define NPC_REQ_LISTEN    3'h2
`define NPC_REQ_SEND      3'h3
`define NPC_REQ_RECEIVE   3'h4
`define NPC_REQ_DISCON    3'h5
`define NPC_NET_NEXUS_ON_DISC 1'b1
`endif

// *** src/npc_pkg.sv ***
// types for the network port connection manager
package npc_pkg;
    typedef enum logic [2:0]
    {
        NPC_NOT_CONN = 3'h0,
        NPC_LISTEN   = 3'h1,
        NPC_CONNING  = 3'h2,
        NPC_CONN     = 3'h3,
        NPC_DISCING  = 3'h4
    } npc_state_t;

    typedef enum logic [2:0]
    {
        NPC_OP_NONE    = 3'h0,
        NPC_OP_LISTEN  = 3'h1,
        NPC_OP_OPEN    = 3'h2,
        NPC_OP_CLOSE   = 3'h3,
        NPC_OP_SHUT    = 3'h4
    } npc_op_t;
endpackage : npc_pkg

// *** src/npc_timeout.sv ***
// acknowledgement time-out holder
`timescale 1ns/100ps
`include "npc_defines.svh"
module npc_timeout #(
    parameter int unsigned W = 32,
    parameter logic [W-1:0] INIT = W'(`NPC_ACK_TO_CYC)
)
(
    input  wire logic         sys_clk_i,
    input  wire logic         reset_i,
    input  wire logic         serial_mode_i,
    input  wire logic         param_chg_i,
    input  wire logic [W-1:0] param_to_i,
    input  wire logic         to_iu_i,
    input  wire logic [W-1:0] to_iu_val_i,
    output logic      [W-1:0] ack_to_o
);
    typedef struct packed
    {
        logic [W-1:0] to;
    } npc_to_st_t;

    npc_to_st_t st_r;
    npc_to_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (serial_mode_i && param_chg_i)
            st_nxt.to = param_to_i;
        else if (!serial_mode_i && to_iu_i)
            st_nxt.to = to_iu_val_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            st_r <= '{to: INIT};
        else
            st_r <= st_nxt;
    end

    assign ack_to_o = st_r.to;
endmodule : npc_timeout

// *** tb/npc_conn_bench.sv ***
// self-checking bench for the connection manager
`timescale 1ns/100ps
module npc_conn_bench;
    logic        sys_clk_i = 1'b0, reset_i = 1'b1;
    logic [2:0]  req_i = 3'h0;
    logic [7:0]  req_data_i = 8'h00, send_data_i = 8'h00;
    logic        remote_req_i = 1'b0, disc_ind_i = 1'b0, login_tx_i = 1'b0;
    logic        login_rx_i = 1'b0, login_reset_flag_i = 1'b0;
    logic        ack_of_reset_i = 1'b0, remote_reset_i = 1'b0;
    logic        serial_disc_i = 1'b0, host_sense_i = 1'b1;
    logic        serial_mode_i = 1'b0, param_chg_i = 1'b0, to_iu_i = 1'b0;
    logic [31:0] param_to_i = 32'h0, to_iu_val_i = 32'h0, ack_to_o;
    logic        refuse_i = 1'b0, send_i = 1'b0;
    logic [3:0]  delay_i = 4'h6;
    logic        accept_ok_i, accept_fail_i, connect_ok_i, connect_fail_i;
    logic        rx_valid_i, rx_fail_i, tx_valid_o, refuse_remote_o;
    logic [7:0]  rx_data_i, tx_data_o, rcv_data_o;
    logic [2:0]  net_op_o, state_o;
    logic        connected_o, disconnected_o, received_o, reject_o;
    logic        nexus_loss_o, host_present_o;
    int          n_fail = 0, total_checks = 0, cyc = 0;

    npc_conn dut_u (.*);
    npc_remote_model far_u (.*, .net_op_i(net_op_o),
        .accept_ok_o(accept_ok_i), .accept_fail_o(accept_fail_i),
        .connect_ok_o(connect_ok_i), .connect_fail_o(connect_fail_i),
        .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_fail_o(rx_fail_i));

    always #10 sys_clk_i = ~sys_clk_i;
    // run needs about 120 cycles; a hang is cut well after that
    always @(posedge sys_clk_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            summarize();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task summarize;
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // wide enough for the state plus the full time-out word
    task cmp(input logic [39:0] got, input logic [39:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : cmp

    task go(input logic [2:0] r);
        @(negedge sys_clk_i);
        req_i = r;
        @(negedge sys_clk_i);
        req_i = 3'h0;
    endtask : go

    task rx(input logic [7:0] d);
        @(negedge sys_clk_i);
        send_i = 1'b1;
        send_data_i = d;
        @(negedge sys_clk_i);
        send_i = 1'b0;
        @(negedge sys_clk_i);
    endtask : rx

    task automatic await(input bit dis);
        int n;
        n = 0;
        while ((dis ? disconnected_o : connected_o) !== 1'b1 && n < 40)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        cmp(n < 40, 1'b1, "no indication");
    endtask : await

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_idle;
        for (int k = 3; k < 6; k++)
        begin
            go(3'(k));
            cmp({reject_o, state_o}, 4'h8, "idle reject");
        end
        remote_req_i = 1'b1;
        @(negedge sys_clk_i);
        remote_req_i = 1'b0;
        cmp(refuse_remote_o, 1'b1, "idle remote");
        rx(8'h3c);
        cmp(received_o, 1'b0, "idle rx");
    endtask : t_idle

    task automatic t_nexus;
        for (int k = 0; k < 7; k++)
        begin
            @(negedge sys_clk_i);
            case (k)
                0: {login_tx_i, login_reset_flag_i} = 2'h3;
                1: {login_rx_i, login_reset_flag_i} = 2'h3;
                2: ack_of_reset_i = 1'b1;
                3: remote_reset_i = 1'b1;
                4: serial_disc_i = 1'b1;
                5: host_sense_i = 1'b0;
                default: login_tx_i = 1'b1;
            endcase
            @(negedge sys_clk_i);
            cmp(nexus_loss_o, k != 6, "nexus");
            cmp(host_present_o, k != 5, "sense");
            {login_tx_i, login_rx_i, login_reset_flag_i} = 3'h0;
            {ack_of_reset_i, remote_reset_i, serial_disc_i} = 3'h0;
            host_sense_i = 1'b1;
        end
    endtask : t_nexus

    task t_timeout;
        to_iu_i = 1'b1;
        to_iu_val_i = 32'h0000_1234;
        @(negedge sys_clk_i);
        to_iu_i = 1'b0;
        cmp(ack_to_o, 32'h0000_1234, "time-out unit");
        serial_mode_i = 1'b1;
        param_chg_i = 1'b1;
        param_to_i = 32'h0000_0abc;
        @(negedge sys_clk_i);
        param_chg_i = 1'b0;
        serial_mode_i = 1'b0;
        cmp(ack_to_o, 32'h0000_0abc, "serial time-out");
    endtask : t_timeout

    task t_listen;
        refuse_i = 1'b1;
        go(3'h2);
        cmp({state_o, net_op_o}, 6'h09, "listen");
        await(1'b1);
        cmp(state_o, 3'h0, "accept fail");
        refuse_i = 1'b0;
        go(3'h2);
        rx(8'h5a);
        cmp(received_o, 1'b0, "listen rx");
        await(1'b0);
        cmp(state_o, 3'h3, "accepted");
    endtask : t_listen

    task t_data;
        req_data_i = 8'ha5;
        go(3'h3);
        cmp({tx_valid_o, tx_data_o}, 9'h1a5, "send");
        go(3'h1);
        cmp({reject_o, state_o}, 4'hb, "conn refuse");
        go(3'h4);
        cmp(reject_o, 1'b0, "receive");
        rx(8'hc3);
        cmp({received_o, rcv_data_o}, 9'h1c3, "conn rx");
        disc_ind_i = 1'b1;
        @(negedge sys_clk_i);
        disc_ind_i = 1'b0;
        cmp({state_o, nexus_loss_o}, 4'h1, "drop");
    endtask : t_data

    task t_refuse;
        refuse_i = 1'b1;
        go(3'h1);
        cmp({state_o, net_op_o}, 6'h12, "open");
        go(3'h2);
        cmp({reject_o, state_o}, 4'ha, "conning reject");
        await(1'b1);
        cmp(state_o, 3'h0, "refused");
        refuse_i = 1'b0;
        delay_i = 4'hf;
        go(3'h2);
        go(3'h1);
        cmp({state_o, net_op_o}, 6'h12, "listen to open");
        go(3'h5);
        cmp({state_o, disconnected_o}, 4'h1, "abort");
    endtask : t_refuse

    task t_close;
        go(3'h1);
        await(1'b0);
        go(3'h5);
        cmp({state_o, net_op_o}, 6'h24, "shutdown");
        req_data_i = 8'h77;
        go(3'h3);
        cmp({reject_o, tx_valid_o}, 2'h2, "drain send");
        rx(8'h81);
        cmp({received_o, rcv_data_o}, 9'h181, "drain rx");
        remote_req_i = 1'b1;
        @(negedge sys_clk_i);
        remote_req_i = 1'b0;
        cmp(refuse_remote_o, 1'b1, "drain remote");
        await(1'b1);
        cmp({state_o, nexus_loss_o}, 4'h1, "closed");
    endtask : t_close

    initial
    begin
        repeat (5) @(negedge sys_clk_i);
        reset_i = 1'b0;
        cmp({state_o, ack_to_o}, 35'h0773_5940, "reset");
        t_idle();
        t_nexus();
        t_timeout();
        t_listen();
        t_data();
        t_refuse();
        t_close();
        summarize();
    end
endmodule : npc_conn_bench

// *** tb/npc_conn_props.sv ***
// assertions on the connection manager ports
`timescale 1ns/100ps
module npc_conn_props #(
    parameter int unsigned     DW         = 8,
    parameter int unsigned     TO_W       = 32,
    parameter logic [TO_W-1:0] ACK_TO_CYC = '0
)
(
    // clock, reset and requests
    input wire logic            sys_clk_i, reset_i,
    input wire logic [2:0]      req_i,
    input wire logic [DW-1:0]   req_data_i, rx_data_i,
    // network events
    input wire logic            accept_fail_i, connect_ok_i,
    input wire logic            connect_fail_i, rx_valid_i, rx_fail_i,
    input wire logic            disc_ind_i, serial_mode_i, to_iu_i,
    // outputs watched
    input wire logic [2:0]      net_op_o, state_o,
    input wire logic            tx_valid_o, connected_o, disconnected_o,
    input wire logic            received_o, nexus_loss_o,
    input wire logic [DW-1:0]   tx_data_o, rcv_data_o,
    input wire logic [TO_W-1:0] ack_to_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_boot_values: assert property
        ($fell(reset_i) |-> state_o == 3'h0 && ack_to_o == ACK_TO_CYC)
        else $error("bad state after reset");
    chk_listen_fail: assert property
        (state_o == 3'h1 && accept_fail_i && req_i != 3'h1
        |=> state_o == 3'h0 && disconnected_o) else $error("accept fail");
    chk_conning_drop: assert property
        (state_o == 3'h2 && (req_i == 3'h5 || connect_fail_i)
        |=> state_o == 3'h0 && disconnected_o) else $error("open drop");
    chk_conning_ok: assert property
        (state_o == 3'h2 && connect_ok_i && !connect_fail_i && req_i == 3'h0
        |=> state_o == 3'h3 && connected_o) else $error("open ok");
    chk_send_copy: assert property
        (state_o == 3'h3 && req_i == 3'h3 && !disc_ind_i
        |=> tx_valid_o && tx_data_o == $past(req_data_i))
        else $error("send lost");
    chk_shut_start: assert property
        (state_o == 3'h3 && req_i == 3'h5 && !disc_ind_i
        |=> state_o == 3'h4 && net_op_o == 3'h4) else $error("no shutdown");
    chk_ind_drop: assert property
        (state_o == 3'h3 && disc_ind_i |=> state_o == 3'h0)
        else $error("indication ignored");
    chk_drain_rx: assert property
        (state_o == 3'h4 && rx_valid_i && !rx_fail_i
        |=> received_o && rcv_data_o == $past(rx_data_i) && !tx_valid_o)
        else $error("drain rx");
    chk_close_done: assert property
        (state_o == 3'h4 && rx_fail_i
        |=> state_o == 3'h0 && disconnected_o && nexus_loss_o)
        else $error("close not seen");
    chk_timeout_hold: assert property
        (!serial_mode_i && !to_iu_i |=> $stable(ack_to_o))
        else $error("time-out moved");
endmodule : npc_conn_props

bind npc_conn npc_conn_props #(.DW(DW), .TO_W(TO_W), .ACK_TO_CYC(ACK_TO_CYC))
    props_u (.*);

// *** tb/npc_remote_model.sv ***
// behavioural model of the remote network port
`timescale 1ns/100ps
module npc_remote_model (
    // commands from the bench
    input  wire logic       sys_clk_i,
    input  wire logic       refuse_i,
    input  wire logic [3:0] delay_i,
    input  wire logic       send_i,
    input  wire logic [7:0] send_data_i,
    // operations from the port
    input  wire logic [2:0] net_op_i,
    // results towards the port
    output logic            accept_ok_o = 1'b0,
    output logic            accept_fail_o = 1'b0,
    output logic            connect_ok_o = 1'b0,
    output logic            connect_fail_o = 1'b0,
    output logic            rx_valid_o = 1'b0,
    output logic [7:0]      rx_data_o = 8'h00,
    output logic            rx_fail_o = 1'b0
);
    logic [2:0] pend_r = 3'h0;
    logic [3:0] cnt_r  = 4'h0;

    always @(posedge sys_clk_i)
    begin
        {accept_ok_o, accept_fail_o, connect_ok_o, connect_fail_o} <= 4'h0;
        rx_fail_o  <= 1'b0;
        rx_valid_o <= send_i;
        // idle line toggles so a stale byte never looks fresh
        rx_data_o  <= send_i ? send_data_i : ~rx_data_o;
        // any new operation replaces the one still pending
        if (net_op_i != 3'h0)
        begin
            pend_r <= net_op_i;
            cnt_r  <= delay_i;
        end
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
        else if (pend_r != 3'h0)
        begin
            pend_r         <= 3'h0;
            accept_ok_o    <= pend_r == 3'h1 && !refuse_i;
            accept_fail_o  <= pend_r == 3'h1 && refuse_i;
            connect_ok_o   <= pend_r == 3'h2 && !refuse_i;
            connect_fail_o <= pend_r == 3'h2 && refuse_i;
            rx_fail_o      <= pend_r == 3'h4;
        end
    end
endmodule : npc_remote_model
